// ===== rtl/pwm_capture_timer16.sv
// 16-bit timer/counter with prescaler, capture, autoreload, clock output and pwm output
//
// Local design decision: strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "timer16_cfg.svh"

module pwm_capture_timer16 (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire timer16_pkg::reg_req_s req,
  output logic [15:0]               rdata,
  input  wire logic                 pin_a_in,
  output logic                      pin_a_out,
  output logic                      pin_a_oe,
  input  wire logic                 pin_b_in,
  output logic                      pin_b_out,
  output logic                      pin_b_oe,
  output logic                      timer_irq
);

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  function automatic logic [9:0] presc_last(input logic [2:0] sel);
    logic [9:0] r;
    r = `PRE_LAST_1;
    unique case (sel)
      3'h1:    r = `PRE_LAST_4;
      3'h2:    r = `PRE_LAST_16;
      3'h3:    r = `PRE_LAST_64;
      3'h4:    r = `PRE_LAST_256;
      3'h5:    r = `PRE_LAST_1024;
      default: r = `PRE_LAST_1;
    endcase
    return r;
  endfunction

  function automatic logic wr_at(input timer16_pkg::reg_req_s q, input logic [4:0] a);
    return q.wr && (q.addr == a);
  endfunction

  // ----------------------------------------------------------------------
  // state and mode decode
  // ----------------------------------------------------------------------
  timer16_pkg::timer_state_s st_ff;
  timer16_pkg::timer_state_s nxt_st;
  timer16_pkg::out_mode_e    out_mode;

  logic        run;
  logic        csel;
  logic        capm;
  logic        ext_en;
  logic        ud;
  logic        pwm_on;
  logic        clkout;
  logic        ud_pin;
  logic        ud_pwm;
  logic        pre_hit;
  logic        fall_a;
  logic        fall_b;
  logic        tick;
  logic        count_up;
  logic [2:0]  pre_sel;
  logic [15:0] limit_m1;

  assign run      = st_ff.ctrl[`BIT_RUN];
  assign csel     = st_ff.ctrl[`BIT_COUNTER_SEL];
  assign capm     = st_ff.ctrl[`BIT_CAPTURE_SEL];
  assign ext_en   = st_ff.ctrl[`BIT_EXT_EN];
  assign ud       = st_ff.ctrl[`BIT_UPDOWN];
  assign pre_sel  = st_ff.ctrl[`BIT_PRE_HI:`BIT_PRE_LO];
  assign out_mode = timer16_pkg::out_mode_e'(st_ff.ctrl[`BIT_PIN_SET:`BIT_PIN_RESET]);
  assign pwm_on   = (out_mode != timer16_pkg::OUT_NONE);
  assign clkout   = st_ff.ctrl[`BIT_CLK_OE] && !csel && !capm;
  assign ud_pin   = !capm && ud && !pwm_on && !clkout;
  assign ud_pwm   = !capm && ud && pwm_on && !clkout;
  assign limit_m1 = (st_ff.limit == `COUNT_ZERO) ? `COUNT_ZERO : st_ff.limit - `COUNT_ONE;

  // edges seen only on settled synchroniser stages
  assign fall_a   = st_ff.a_sync[2] && !st_ff.a_sync[1];
  assign fall_b   = st_ff.b_sync[2] && !st_ff.b_sync[1];

  assign pre_hit  = (st_ff.presc == presc_last(pre_sel));
  assign tick     = run && (csel ? fall_a : pre_hit);
  assign count_up = ud_pin ? st_ff.b_sync[1] : (ud_pwm ? st_ff.dir_up : 1'b1);

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic        ovf_ev;
    logic        ext_set;
    logic        ext_tog;
    logic        cmp_hit;
    logic        zero_hit;
    logic        lim_hit;
    logic [15:0] cnt_new;
    logic [15:0] ctrl_base;
    ovf_ev    = 1'b0;
    ext_set   = 1'b0;
    ext_tog   = 1'b0;
    cmp_hit   = 1'b0;
    zero_hit  = 1'b0;
    lim_hit   = 1'b0;
    cnt_new   = st_ff.count;
    ctrl_base = st_ff.ctrl;
    nxt_st    = st_ff;

    // synchronisers
    nxt_st.a_sync = {st_ff.a_sync[1:0], pin_a_in};
    nxt_st.b_sync = {st_ff.b_sync[1:0], pin_b_in};

    // prescaler
    nxt_st.presc = (!run || pre_hit) ? 10'h000 : st_ff.presc + 10'h001;

    // counting
    if (tick) begin
      if (capm) begin
        cnt_new = st_ff.count + `COUNT_ONE;
        ovf_ev  = (st_ff.count == `COUNT_MAX);
      end else if (clkout) begin
        if (st_ff.count >= limit_m1) begin
          cnt_new      = `COUNT_ZERO;
          nxt_st.pin_a = !st_ff.pin_a;
          ovf_ev       = 1'b1;
        end else begin
          cnt_new = st_ff.count + `COUNT_ONE;
        end
      end else if (count_up) begin
        if (st_ff.count == st_ff.limit) begin
          ovf_ev = 1'b1;
          if (ud_pwm) begin
            nxt_st.dir_up = 1'b0;
            cnt_new       = limit_m1;
          end else begin
            cnt_new = `COUNT_ZERO;
          end
        end else begin
          cnt_new = st_ff.count + `COUNT_ONE;
        end
      end else begin
        if (st_ff.count == `COUNT_ZERO) begin
          ovf_ev = 1'b1;
          if (ud_pwm) begin
            nxt_st.dir_up = 1'b1;
            cnt_new       = (st_ff.limit == `COUNT_ZERO) ? `COUNT_ZERO : `COUNT_ONE;
          end else begin
            cnt_new = st_ff.limit;
          end
        end else begin
          cnt_new = st_ff.count - `COUNT_ONE;
        end
      end
    end

    // external edge on pin b, reload ignored while pwm stage owns the pin
    if (run && fall_b && ext_en && !capm && !ud && !pwm_on && !clkout) begin
      cnt_new = `COUNT_ZERO;
    end
    if (fall_b && ext_en && capm) begin
      nxt_st.limit = st_ff.count;
    end
    ext_set = fall_b && ext_en && (capm || !ud || pwm_on);
    ext_tog = ud_pin && ovf_ev;

    // output stage on pin b
    cmp_hit  = tick && (cnt_new == st_ff.compare);
    zero_hit = tick && (cnt_new == `COUNT_ZERO);
    lim_hit  = tick && (cnt_new == st_ff.limit);
    if (!run) begin
      if (out_mode == timer16_pkg::OUT_RESET) begin
        nxt_st.pin_b = 1'b0;
      end else if (out_mode == timer16_pkg::OUT_SET) begin
        nxt_st.pin_b = 1'b1;
      end
    end else begin
      unique case (out_mode)
        timer16_pkg::OUT_RESET: begin
          if (cmp_hit && st_ff.compare != `COUNT_ZERO && st_ff.compare <= st_ff.limit) begin
            nxt_st.pin_b = 1'b0;
          end else if (zero_hit) begin
            nxt_st.pin_b = 1'b1;
          end
        end
        timer16_pkg::OUT_SET: begin
          if (cmp_hit && st_ff.compare < st_ff.limit) begin
            nxt_st.pin_b = 1'b1;
          end else if (lim_hit) begin
            nxt_st.pin_b = 1'b0;
          end
        end
        timer16_pkg::OUT_TOGGLE: begin
          if (cmp_hit && st_ff.compare != `COUNT_ZERO && st_ff.compare < st_ff.limit) begin
            nxt_st.pin_b = !st_ff.pin_b;
          end
        end
        timer16_pkg::OUT_NONE: begin
          nxt_st.pin_b = st_ff.pin_b;
        end
      endcase
    end

    // register writes; hardware flag events win over a clearing write
    if (wr_at(req, `ADDR_CONTROL)) begin
      ctrl_base = req.wdata & `CONTROL_MASK;
    end
    nxt_st.ctrl                = ctrl_base;
    nxt_st.ctrl[`BIT_OVF_FLAG] = ctrl_base[`BIT_OVF_FLAG] || ovf_ev;
    nxt_st.ctrl[`BIT_EXT_FLAG] = (ctrl_base[`BIT_EXT_FLAG] ^ ext_tog) || ext_set;
    nxt_st.count = wr_at(req, `ADDR_COUNT) ? req.wdata : cnt_new;
    if (wr_at(req, `ADDR_LIMIT)) begin
      nxt_st.limit = req.wdata;
    end
    if (wr_at(req, `ADDR_COMPARE)) begin
      nxt_st.compare = req.wdata;
    end

    // read data, valid one cycle after the strobe
    nxt_st.rdata = 16'h0000;
    if (req.rd) begin
      unique case (req.addr)
        `ADDR_CONTROL: nxt_st.rdata = st_ff.ctrl & `CONTROL_MASK;
        `ADDR_LIMIT:   nxt_st.rdata = st_ff.limit;
        `ADDR_COUNT:   nxt_st.rdata = st_ff.count;
        `ADDR_COMPARE: nxt_st.rdata = st_ff.compare;
        default:       nxt_st.rdata = 16'h0000;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      st_ff.ctrl    <= `CONTROL_RST;
      st_ff.count   <= `COUNT_RST;
      st_ff.limit   <= `LIMIT_RST;
      st_ff.compare <= `COMPARE_RST;
      st_ff.presc   <= 10'h000;
      st_ff.a_sync  <= 3'h7;
      st_ff.b_sync  <= 3'h7;
      st_ff.dir_up  <= 1'b1;
      st_ff.pin_a   <= 1'b0;
      st_ff.pin_b   <= 1'b0;
      st_ff.rdata   <= 16'h0000;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign rdata     = st_ff.rdata;
  assign pin_a_out = st_ff.pin_a;
  assign pin_a_oe  = clkout;
  assign pin_b_out = st_ff.pin_b;
  assign pin_b_oe  = pwm_on;
  assign timer_irq = st_ff.ctrl[`BIT_IRQ_EN] &&
                     ((st_ff.ctrl[`BIT_OVF_FLAG] && !st_ff.ctrl[`BIT_CLK_OE]) ||
                      (st_ff.ctrl[`BIT_EXT_FLAG] && !ud_pin));

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  logic cnt_wr;
  logic ctl_wr;
  logic lim_wr;
  logic div4_cfg;
  assign cnt_wr   = wr_at(req, `ADDR_COUNT);
  assign ctl_wr   = wr_at(req, `ADDR_CONTROL);
  assign lim_wr   = wr_at(req, `ADDR_LIMIT);
  assign div4_cfg = run && !csel && (pre_sel == 3'h1);

  sequence s_div4_held;
    (tick && div4_cfg) ##1 div4_cfg [*4];
  endsequence

  a_run_halts_count: assert property ((!run && !cnt_wr) |=> $stable(st_ff.count))
    else $error("count moved while stopped");

  a_prescale_div4: assert property (s_div4_held |-> tick && $past(!tick) && $past(!tick, 2) && $past(!tick, 3))
    else $error("prescale by four period wrong");

  a_autoreload_wrap: assert property ((tick && !capm && !clkout && count_up && !ud_pwm && !cnt_wr && !ctl_wr &&
                                       st_ff.count == st_ff.limit) |=> (st_ff.count == `COUNT_ZERO) &&
                                      st_ff.ctrl[`BIT_OVF_FLAG])
    else $error("autoreload match did not reload zero");

  a_ext_reload: assert property ((run && fall_b && ext_en && !capm && !ud && !pwm_on && !clkout && !cnt_wr)
                                 |=> st_ff.count == `COUNT_ZERO)
    else $error("pin b fall did not reload");

  a_capture_wrap: assert property ((tick && capm && st_ff.count == `COUNT_MAX && !cnt_wr && !ctl_wr)
                                   |=> st_ff.count == `COUNT_ZERO && st_ff.ctrl[`BIT_OVF_FLAG])
    else $error("capture mode wrap wrong");

  a_capture_copy: assert property ((fall_b && ext_en && capm && !lim_wr && !ctl_wr)
                                   |=> st_ff.limit == $past(st_ff.count) && st_ff.ctrl[`BIT_EXT_FLAG])
    else $error("capture did not copy count");

  a_updown_under: assert property ((tick && ud_pin && !count_up && st_ff.count == `COUNT_ZERO && !cnt_wr)
                                   |=> st_ff.count == $past(st_ff.limit))
    else $error("underflow did not load limit");

  a_ud_ext_toggle: assert property ((tick && ud_pin && !ctl_wr && !fall_b &&
                                     ((count_up && st_ff.count == st_ff.limit) ||
                                      (!count_up && st_ff.count == `COUNT_ZERO)))
                                    |=> st_ff.ctrl[`BIT_EXT_FLAG] != $past(st_ff.ctrl[`BIT_EXT_FLAG]))
    else $error("external flag did not toggle");

  a_stop_pin_level: assert property ((!run && out_mode == timer16_pkg::OUT_RESET) |=> !pin_b_out)
    else $error("stopped reset mode pin not low");

  a_flag_set_wins: assert property ((tick && capm && st_ff.count == `COUNT_MAX && ctl_wr &&
                                     !req.wdata[`BIT_OVF_FLAG]) |=> st_ff.ctrl[`BIT_OVF_FLAG])
    else $error("overflow event lost under clear");

  a_stop_pin_high: assert property ((!run && out_mode == timer16_pkg::OUT_SET) |=> pin_b_out)
    else $error("stopped set mode pin not high");

  a_clkout_flip: assert property ((tick && clkout && st_ff.count >= limit_m1)
                                  |=> pin_a_out != $past(pin_a_out))
    else $error("clock output did not toggle");

  sequence s_b_fall_in;
    st_ff.b_sync[0] && !pin_b_in;
  endsequence

  a_b_fall_seen: assert property (s_b_fall_in |-> ##2 fall_b)
    else $error("pin b fall not seen after two cycles");

  a_irq_on_ovf: assert property ((st_ff.ctrl[`BIT_IRQ_EN] && st_ff.ctrl[`BIT_OVF_FLAG] &&
                                  !st_ff.ctrl[`BIT_CLK_OE]) |-> timer_irq)
    else $error("overflow flag raised no interrupt");

  a_capture_off: assert property ((fall_b && !ext_en && !lim_wr) |=> $stable(st_ff.limit))
    else $error("limit changed without edge enable");

  a_updown_up: assert property ((tick && ud_pin && count_up && st_ff.count != st_ff.limit && !cnt_wr)
                                |=> st_ff.count == $past(st_ff.count) + `COUNT_ONE)
    else $error("up count step wrong");

endmodule
`default_nettype wire

// ===== rtl/timer16_cfg.svh
// register offsets, control bit positions, reset values and prescale counts
`ifndef TIMER16_CFG_SVH
`define TIMER16_CFG_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define ADDR_CONTROL    5'h06
`define ADDR_LIMIT      5'h09
`define ADDR_COUNT      5'h0a
`define ADDR_COMPARE    5'h0b

// ----------------------------------------------------------------------
// control bit positions
// ----------------------------------------------------------------------
`define BIT_COUNTER_SEL 15
`define BIT_PIN_SET     12
`define BIT_PIN_RESET   11
`define BIT_PRE_HI      10
`define BIT_PRE_LO      8
`define BIT_OVF_FLAG    7
`define BIT_EXT_FLAG    6
`define BIT_CLK_OE      5
`define BIT_UPDOWN      4
`define BIT_EXT_EN      3
`define BIT_RUN         2
`define BIT_IRQ_EN      1
`define BIT_CAPTURE_SEL 0

// ----------------------------------------------------------------------
// reset values and masks
// ----------------------------------------------------------------------
`define CONTROL_RST     16'h0000
`define CONTROL_MASK    16'h9fff
`define LIMIT_RST       16'h0000
`define COUNT_RST       16'h0000
`define COMPARE_RST     16'h0000
`define COUNT_MAX       16'hffff
`define COUNT_ZERO      16'h0000
`define COUNT_ONE       16'h0001

// ----------------------------------------------------------------------
// prescale terminal counts
// ----------------------------------------------------------------------
`define PRE_LAST_1      10'h000
`define PRE_LAST_4      10'h003
`define PRE_LAST_16     10'h00f
`define PRE_LAST_64     10'h03f
`define PRE_LAST_256    10'h0ff
`define PRE_LAST_1024   10'h3ff

`endif

// ===== rtl/timer16_pkg.sv
// types shared by the timer block
package timer16_pkg;

  // ----------------------------------------------------------------------
  // register port request
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [4:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_s;

  // ----------------------------------------------------------------------
  // output stage modes
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    OUT_NONE   = 2'b00,
    OUT_RESET  = 2'b01,
    OUT_SET    = 2'b10,
    OUT_TOGGLE = 2'b11
  } out_mode_e;

  // ----------------------------------------------------------------------
  // whole state of the timer
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] count;
    logic [15:0] limit;
    logic [15:0] compare;
    logic [9:0]  presc;
    logic [2:0]  a_sync;
    logic [2:0]  b_sync;
    logic        dir_up;
    logic        pin_a;
    logic        pin_b;
    logic [15:0] rdata;
  } timer_state_s;

endpackage

// ===== test/pin_driver.sv
// far-side pin driver that resolves both shared pin wires
`timescale 1ns/10ps
`default_nettype none

module pin_driver (
  input  wire logic a_drv,
  input  wire logic b_drv,
  input  wire logic a_out,
  input  wire logic a_oe,
  input  wire logic b_out,
  input  wire logic b_oe,
  output logic      a_wire,
  output logic      b_wire
);
  // ------------------------------------------------------------
  // wire level: the timer wins while it drives
  // ------------------------------------------------------------
  assign a_wire = a_oe ? a_out : a_drv;
  assign b_wire = b_oe ? b_out : b_drv;
endmodule

`default_nettype wire

// ===== test/test_pwm_capture_timer16.sv
// self-checking testbench for the 16-bit pwm capture timer
`timescale 1ns/10ps
`default_nettype none
`include "timer16_cfg.svh"

module test_pwm_capture_timer16;
  logic                  clk = 1'b0;
  logic                  reset = 1'b1;
  timer16_pkg::reg_req_s req = '0;
  logic [15:0]           rdata;
  logic                  a_drv = 1'b1;
  logic                  b_drv = 1'b1;
  logic                  a_in, a_out, a_oe, b_in, b_out, b_oe, irq;
  logic [15:0]           v;
  logic [15:0]           fl;
  logic                  iq;
  int                    failures = 0;
  int                    n_tests = 0;

  always #12.5 clk = ~clk;

  pwm_capture_timer16 uut (.clk(clk), .reset(reset), .req(req), .rdata(rdata), .pin_a_in(a_in),
    .pin_a_out(a_out), .pin_a_oe(a_oe), .pin_b_in(b_in), .pin_b_out(b_out), .pin_b_oe(b_oe), .timer_irq(irq));
  pin_driver far (.a_drv(a_drv), .b_drv(b_drv), .a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe),
    .a_wire(a_in), .b_wire(b_in));

  // ------------------------------------------------------------
  // checking and closing
  // ------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    if (failures == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // register port and pin helpers
  // ------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic chk_reg(input logic [4:0] a, input logic [15:0] exp);
    rd(a, v);
    chk(v, exp);
  endtask

  // run for g cycles, sampling flags and irq just before the stop
  task automatic run_for(input logic [15:0] c, input int g);
    wr(`ADDR_CONTROL, c | 16'h0004);
    cyc(g - 4);
    rd(`ADDR_CONTROL, fl);
    iq = irq;
    wr(`ADDR_CONTROL, c);
  endtask

  task automatic pulse(input logic on_a);
    @(posedge clk);
    {a_drv, b_drv} <= on_a ? 2'b01 : 2'b10;
    cyc(4);
    {a_drv, b_drv} <= 2'b11;
    cyc(4);
  endtask

  task automatic span(input logic lvl, output int n);
    for (n = 0; n < 300 && a_out !== lvl; n++) begin
      @(negedge clk);
    end
    if (n == 300) begin
      failures++;
      complete_run();
    end
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic s_reset();
    chk_reg(`ADDR_CONTROL, 16'h0000);
    chk_reg(`ADDR_COUNT, 16'h0000);
    chk_reg(`ADDR_COMPARE, 16'h0000);
    chk_reg(5'h1f, 16'h0000);
    chk({14'h0, a_oe, b_oe}, 16'h0000);
  endtask

  task automatic s_hold();
    wr(`ADDR_COUNT, 16'h1234);
    cyc(20);
    chk_reg(`ADDR_COUNT, 16'h1234);
    wr(`ADDR_LIMIT, 16'hffff);
    run_for(16'h0000, 10);
    chk_reg(`ADDR_COUNT, 16'h123e);
    cyc(20);
    chk_reg(`ADDR_COUNT, 16'h123e);
  endtask

  task automatic s_presc();
    int n[8] = '{1, 4, 16, 64, 256, 1024, 1, 1};
    for (int k = 0; k < 8; k++) begin
      wr(`ADDR_COUNT, 16'h0000);
      run_for({5'h0, k[2:0], 8'h00}, n[k] == 1 ? 4 : 4 * n[k] + n[k] / 2);
      chk_reg(`ADDR_COUNT, 16'h0004);
    end
  endtask

  task automatic s_reload();
    wr(`ADDR_LIMIT, 16'h0002);
    wr(`ADDR_COUNT, 16'h0000);
    run_for(16'h0002, 7);
    chk_reg(`ADDR_COUNT, 16'h0001);
    chk(fl & 16'h0080, 16'h0080);
    chk({15'h0, iq}, 16'h0001);
    chk_reg(`ADDR_CONTROL, 16'h0002);
  endtask

  task automatic s_capture();
    wr(`ADDR_LIMIT, 16'h0000);
    wr(`ADDR_COUNT, 16'hfffe);
    run_for(16'h0001, 6);
    chk_reg(`ADDR_COUNT, 16'h0004);
    chk(fl & 16'h0080, 16'h0080);
    for (int e = 0; e < 2; e++) begin
      wr(`ADDR_LIMIT, 16'h0000);
      wr(`ADDR_COUNT, 16'h4321);
      wr(`ADDR_CONTROL, {12'h000, e[0], 3'h1});
      pulse(1'b0);
      chk_reg(`ADDR_LIMIT, e ? 16'h4321 : 16'h0000);
      rd(`ADDR_CONTROL, v);
      chk(v & 16'h0040, e ? 16'h0040 : 16'h0000);
      wr(`ADDR_CONTROL, 16'h0000);
    end
  endtask

  task automatic s_extreload();
    wr(`ADDR_LIMIT, 16'hffff);
    for (int e = 0; e < 2; e++) begin
      wr(`ADDR_COUNT, 16'h0500);
      wr(`ADDR_CONTROL, {12'h050, e[0], 3'h4});
      pulse(1'b0);
      wr(`ADDR_CONTROL, 16'h0000);
      chk_reg(`ADDR_COUNT, e ? 16'h0000 : 16'h0500);
    end
  endtask

  task automatic s_updown();
    wr(`ADDR_LIMIT, 16'h0005);
    wr(`ADDR_COUNT, 16'h0001);
    b_drv <= 1'b0;
    cyc(4);
    run_for(16'h0010, 5);
    chk_reg(`ADDR_COUNT, 16'h0002);
    chk(fl & 16'h00c0, 16'h00c0);
    wr(`ADDR_COUNT, 16'h0004);
    b_drv <= 1'b1;
    cyc(4);
    run_for(16'h0010, 5);
    chk_reg(`ADDR_COUNT, 16'h0003);
    chk(fl & 16'h00c0, 16'h00c0);
  endtask

  task automatic s_clkout();
    int hi;
    int lo;
    wr(`ADDR_LIMIT, 16'h0003);
    wr(`ADDR_COUNT, 16'h0000);
    b_drv <= 1'b0;
    wr(`ADDR_CONTROL, 16'h0034);
    @(negedge clk);
    chk({15'h0, a_oe}, 16'h0001);
    span(1'b0, hi);
    span(1'b1, lo);
    span(1'b0, hi);
    span(1'b1, lo);
    chk(hi[15:0], 16'h0003);
    chk(lo[15:0], 16'h0003);
    wr(`ADDR_CONTROL, 16'h0000);
    b_drv <= 1'b1;
  endtask

  task automatic s_counter();
    wr(`ADDR_LIMIT, 16'hffff);
    wr(`ADDR_COUNT, 16'h0000);
    wr(`ADDR_CONTROL, 16'h8004);
    repeat (5) pulse(1'b1);
    wr(`ADDR_CONTROL, 16'h0000);
    chk_reg(`ADDR_COUNT, 16'h0005);
  endtask

  task automatic st(input logic [1:0] m, input logic e);
    wr(`ADDR_CONTROL, {3'h0, m, 11'h000});
    cyc(3);
    chk({15'h0, b_out}, {15'h0, e});
  endtask

  task automatic pw(input logic [1:0] m, input logic [15:0] c, input int e);
    int h;
    h = 0;
    wr(`ADDR_COMPARE, c);
    wr(`ADDR_CONTROL, {3'h0, m, 11'h004});
    cyc(25);
    chk({15'h0, b_oe}, 16'h0001);
    for (int i = 0; i < 20; i++) begin
      @(negedge clk);
      h += b_out;
    end
    wr(`ADDR_CONTROL, {3'h0, m, 11'h000});
    chk(h[15:0], e[15:0]);
  endtask

  task automatic s_pwm();
    wr(`ADDR_LIMIT, 16'h0009);
    wr(`ADDR_COUNT, 16'h0000);
    st(2'b01, 1'b0);
    st(2'b11, 1'b0);
    st(2'b10, 1'b1);
    st(2'b11, 1'b1);
    pw(2'b01, 16'h0004, 8);
    pw(2'b10, 16'h0004, 10);
    pw(2'b11, 16'h0004, 10);
    pw(2'b01, 16'h0000, 20);
    pw(2'b10, 16'h0009, 0);
    pw(2'b11, 16'h0000, 20);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    s_reset();
    s_hold();
    s_presc();
    s_reload();
    s_capture();
    s_extreload();
    s_updown();
    s_clkout();
    s_counter();
    s_pwm();
    complete_run();
  end
endmodule

`default_nettype wire
